// ### verilog/serial_eeprom_i2c_slave.sv
// Two-wire slave front end and storage array of a 256-byte serial EEPROM
// Notes on behaviour
// - Data change during clock high is control.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - One clock pulse per bit, sampled high.
// - Write two bytes maximum; reads unlimited.
// - Eight-bit bytes, ninth bit acknowledges.
// - Transmitter releases line during acknowledge.
// - Addressed receiver acknowledges every byte; this device refuses a third data byte.
// - Acknowledger holds line low through clock high.
// - After master no-acknowledge, device releases line.
// - Works at both slow and fast bus rates.
// - Stop after write starts timed erase/write.
// - No address acknowledge during erase/write.
// - Reads need no programming clock.
// - Respond only when chip-select pins match.
// - Word pointer advances after every data byte; a refused third write byte leaves it unchanged.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_i2c_slave #(
  parameter logic [15:0] EW_ONE_CYCLES = 16'(serial_eeprom_pkg::EW_ONE_CYCLES),
  parameter logic [15:0] EW_TWO_CYCLES = 16'(serial_eeprom_pkg::EW_TWO_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic program_timing_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  output logic ew_busy
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg, scl_sync_reg, sda_sync_reg;
  logic [2:0] cs_meta_reg, cs_sync_reg;
  logic rst_n, scl_prev_reg, sda_prev_reg, scl_s, sda_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  // Release reset through two flops so all bus-side logic leaves reset together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pins are asynchronous; no glitch filter; each line level must last at least two clk cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      cs_meta_reg <= 3'h0;
      cs_sync_reg <= 3'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
      cs_meta_reg <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      cs_sync_reg <= cs_meta_reg;
    end
  end

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_prev_reg;   // Bit sample point
  assign scl_fall = ~scl_s & scl_prev_reg;   // Data may change here
  // Data edges with clock high are conditions, not data
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  logic [7:0] mem [serial_eeprom_pkg::DEPTH];
  logic mem_we;
  logic [7:0] rd_byte;
  serial_eeprom_pkg::ew_job_t job_reg;
  // Non-volatile contents: no reset; the staged byte or bytes land when the timer ends
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[job_reg.addr] <= job_reg.data0;
      if (job_reg.two) begin
        mem[8'(job_reg.addr + serial_eeprom_pkg::PTR_STEP)] <= job_reg.data1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus-side state
  // ----------------------------------------------------------------
  serial_eeprom_pkg::bus_state_t state_reg, state_next;
  serial_eeprom_pkg::ew_job_t stage_reg, stage_next, job_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] phase_reg, phase_next, wcnt_reg, wcnt_next;
  logic rw_reg, rw_next, busy_reg, busy_next, req_tgl_reg, req_tgl_next;
  logic oe_reg, oe_next, mack_reg, mack_next, done_evt, addr_match;
  logic [2:0] done_sync_reg;
  logic done_tgl_reg, done_tgl_next;  // Timer domain; read here only through done_sync_reg
  assign rd_byte = mem[ptr_reg];
  assign done_evt = done_sync_reg[1] ^ done_sync_reg[2];
  // Fixed type nibble plus pin-selected bits; silent while busy
  assign addr_match = (shift_reg[7:4] == serial_eeprom_pkg::DEV_TYPE)
                      && (shift_reg[3:1] == cs_sync_reg);

  // Next-state logic for the bus engine and the erase/write hand-off
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    rw_next = rw_reg;
    ptr_next = ptr_reg;
    wcnt_next = wcnt_reg;
    stage_next = stage_reg;
    job_next = job_reg;
    busy_next = busy_reg;
    req_tgl_next = req_tgl_reg;
    oe_next = oe_reg;
    mack_next = mack_reg;
    mem_we = 1'b0;
    if (done_evt) begin
      busy_next = 1'b0;              // Timer finished, address accepted again
      mem_we = 1'b1;
    end
    if (start_det) begin
      state_next = serial_eeprom_pkg::ST_RX;
      phase_next = serial_eeprom_pkg::PH_DEV;
      bit_cnt_next = 4'h0;
      wcnt_next = 2'h0;              // Also on repeated start: staged bytes dropped
      oe_next = 1'b0;
    end else if (stop_det) begin
      state_next = serial_eeprom_pkg::ST_IDLE;
      oe_next = 1'b0;
      wcnt_next = 2'h0;
      if ((wcnt_reg != 2'h0) && !busy_reg) begin
        job_next = stage_reg;
        job_next.two = (wcnt_reg == serial_eeprom_pkg::MAX_WRITE_BYTES);
        busy_next = 1'b1;
        req_tgl_next = ~req_tgl_reg;     // Launch erase/write
      end
    end else begin
      unique case (state_reg)
        serial_eeprom_pkg::ST_IDLE: oe_next = 1'b0;
        serial_eeprom_pkg::ST_RX: begin
          if (scl_rise && (bit_cnt_reg < serial_eeprom_pkg::BITS_PER_BYTE)) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (scl_fall && (bit_cnt_reg == serial_eeprom_pkg::BITS_PER_BYTE)) begin
            state_next = serial_eeprom_pkg::ST_ACK;
            oe_next = 1'b1;                // Ninth bit pulled low
            if (phase_reg == serial_eeprom_pkg::PH_DEV) begin
              rw_next = shift_reg[0];
              if (!addr_match || busy_reg) begin
                state_next = serial_eeprom_pkg::ST_IDLE;
                oe_next = 1'b0;
              end
            end else if (phase_reg == serial_eeprom_pkg::PH_WORD) begin
              ptr_next = shift_reg;
            end else if (wcnt_reg < serial_eeprom_pkg::MAX_WRITE_BYTES) begin
              if (wcnt_reg == 2'h0) begin
                stage_next.addr = ptr_reg;
                stage_next.data0 = shift_reg;
              end else begin
                stage_next.data1 = shift_reg;
              end
              wcnt_next = wcnt_reg + 2'h1;
              ptr_next = 8'(ptr_reg + serial_eeprom_pkg::PTR_STEP);
            end else begin
              state_next = serial_eeprom_pkg::ST_IDLE;  // Third byte refused; two kept
              oe_next = 1'b0;
            end
          end
        end
        serial_eeprom_pkg::ST_ACK: begin
          if (scl_fall) begin                // Low held through clock high
            bit_cnt_next = 4'h0;
            oe_next = 1'b0;
            if ((phase_reg == serial_eeprom_pkg::PH_DEV) && rw_reg) begin
              state_next = serial_eeprom_pkg::ST_TX;
              shift_next = rd_byte;        // Array read directly; reads wait on the timer only while busy refuses the address
              ptr_next = 8'(ptr_reg + serial_eeprom_pkg::PTR_STEP);
              oe_next = ~rd_byte[7];
            end else begin
              state_next = serial_eeprom_pkg::ST_RX;
              phase_next = (phase_reg == serial_eeprom_pkg::PH_DEV) ?
                           serial_eeprom_pkg::PH_WORD : serial_eeprom_pkg::PH_DATA;
            end
          end
        end
        serial_eeprom_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (scl_fall) begin
            if (bit_cnt_reg == serial_eeprom_pkg::BITS_PER_BYTE) begin
              state_next = serial_eeprom_pkg::ST_MACK;
              oe_next = 1'b0;              // Release for master acknowledge
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        serial_eeprom_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;            // Master low means more wanted
          end
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (mack_reg) begin
              state_next = serial_eeprom_pkg::ST_TX;   // Unlimited stream
              shift_next = rd_byte;
              ptr_next = 8'(ptr_reg + serial_eeprom_pkg::PTR_STEP);
              oe_next = ~rd_byte[7];
            end else begin
              state_next = serial_eeprom_pkg::ST_IDLE; // Line left high
              oe_next = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Register stage of the bus engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= serial_eeprom_pkg::ST_IDLE;
      phase_reg <= serial_eeprom_pkg::PH_DEV;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wcnt_reg <= 2'h0;
      stage_reg <= serial_eeprom_pkg::JOB_RESET;
      job_reg <= serial_eeprom_pkg::JOB_RESET;
      busy_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      done_sync_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      rw_reg <= rw_next;
      ptr_reg <= ptr_next;
      wcnt_reg <= wcnt_next;
      stage_reg <= stage_next;
      job_reg <= job_next;
      busy_reg <= busy_next;
      req_tgl_reg <= req_tgl_next;
      oe_reg <= oe_next;
      mack_reg <= mack_next;
      done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
    end
  end

  // Open-drain: data always low, enable decides; all straight from flops
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;
  assign ew_busy = busy_reg;

  // ----------------------------------------------------------------
  // Erase/write timer on the programming clock
  // ----------------------------------------------------------------
  logic [1:0] prst_sync_reg;
  logic [2:0] req_sync_reg;
  logic [15:0] ew_cnt_reg, ew_cnt_next;
  logic prst_n, ew_run_reg, ew_run_next;
  // Own reset release so the timer never sees a half-released reset
  always_ff @(posedge program_timing_clock or negedge rst_b) begin
    if (!rst_b) begin
      prst_sync_reg <= 2'h0;
    end else begin
      prst_sync_reg <= {prst_sync_reg[0], 1'b1};
    end
  end
  assign prst_n = prst_sync_reg[1];

  // Job fields are held steady while busy, so only the toggle is synced
  always_comb begin
    ew_cnt_next = ew_cnt_reg;
    ew_run_next = ew_run_reg;
    done_tgl_next = done_tgl_reg;
    if (req_sync_reg[1] ^ req_sync_reg[2]) begin
      ew_run_next = 1'b1;
      ew_cnt_next = job_reg.two ? EW_TWO_CYCLES : EW_ONE_CYCLES;
    end else if (ew_run_reg) begin
      if (ew_cnt_reg <= serial_eeprom_pkg::EW_CNT_LAST) begin
        ew_run_next = 1'b0;
        done_tgl_next = ~done_tgl_reg;
      end else begin
        ew_cnt_next = ew_cnt_reg - 16'h0001;
      end
    end
  end

  // Register stage of the timer
  always_ff @(posedge program_timing_clock or negedge prst_n) begin
    if (!prst_n) begin
      req_sync_reg <= 3'h0;
      ew_cnt_reg <= 16'h0000;
      ew_run_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      ew_cnt_reg <= ew_cnt_next;
      ew_run_reg <= ew_run_next;
      done_tgl_reg <= done_tgl_next;
    end
  end

endmodule

`default_nettype wire

// ### verilog/serial_eeprom_pkg.sv
// Shared constants, types and states for the serial EEPROM slave
package serial_eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry and slave address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEPTH = 256;
  localparam logic [3:0] DEV_TYPE = 4'ha;      // Fixed upper address nibble, plain default
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] MAX_WRITE_BYTES = 2'h2;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Erase/write timing, counted on the programming clock
  // ----------------------------------------------------------------
  localparam int EW_ONE_TIME_MS = 30;
  localparam int EW_TWO_TIME_MS = 60;
  localparam int PTC_NOM_HZ = 8000;            // Nominal programming clock rate
  localparam int EW_ONE_CYCLES = EW_ONE_TIME_MS * PTC_NOM_HZ / 1000;
  localparam int EW_TWO_CYCLES = EW_TWO_TIME_MS * PTC_NOM_HZ / 1000;
  localparam logic [15:0] EW_CNT_LAST = 16'h0001;

  // ----------------------------------------------------------------
  // Byte role within a transfer
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_DEV = 2'h0;
  localparam logic [1:0] PH_WORD = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  // ----------------------------------------------------------------
  // Bus-side state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } bus_state_t;

  // Staged erase/write job: start address and up to two bytes
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data0;
    logic [7:0] data1;
    logic two;
  } ew_job_t;

  localparam ew_job_t JOB_RESET = '{addr: 8'h00, data0: 8'h00, data1: 8'h00, two: 1'b0};

endpackage

// ### tb/serial_eeprom_i2c_slave_checker.sv
// Port-level assertions for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_checker #(
  parameter logic [15:0] EW_ONE_CYCLES = 16'h0004,
  parameter logic [15:0] EW_TWO_CYCLES = 16'h0008
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic program_timing_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic ew_busy
);
  // ------
  // Programming clock rises counted while busy
  // ------
  logic [1:0] ptc_reg;
  logic [15:0] ticks_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptc_reg <= 2'h0;
      ticks_reg <= 16'h0000;
    end else begin
      ptc_reg <= {ptc_reg[0], program_timing_clock};
      ticks_reg <= !ew_busy ? 16'h0000 : ticks_reg + 16'(ptc_reg == 2'h1);
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ------
  // Assertions
  // ------
  a_open_drain: assert property (!sda_out)
    else $error("data driven high");
  a_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved under high clock");
  a_ack_hold: assert property ($rose(scl_in) && sda_oe |=> sda_oe [*8])
    else $error("low level dropped in high clock");
  a_start_listen: assert property (scl_in && $fell(sda_in) |-> !sda_oe [*8])
    else $error("driving right after start");
  a_stop_release: assert property (scl_in && $rose(sda_in) |=> !sda_oe [*8])
    else $error("driving after stop");
  a_busy_no_ack: assert property (ew_busy |-> !$rose(sda_oe))
    else $error("answered while busy");
  a_busy_after_stop: assert property ($rose(ew_busy) |-> scl_in && sda_in)
    else $error("busy began inside a transfer");
  a_busy_min_len: assert property ($fell(ew_busy) |-> ticks_reg >= EW_ONE_CYCLES)
    else $error("erase/write too short");
  a_busy_max_len: assert property (ticks_reg <= EW_TWO_CYCLES + 16'h0006)
    else $error("erase/write too long");

  c_busy_start: cover property ($rose(ew_busy));
  c_busy_end: cover property ($fell(ew_busy));
  c_ack: cover property ($rose(scl_in) && sda_oe);
endmodule

bind serial_eeprom_i2c_slave serial_eeprom_i2c_slave_checker #(
  .EW_ONE_CYCLES(EW_ONE_CYCLES), .EW_TWO_CYCLES(EW_TWO_CYCLES)
) chk (.clk, .rst_b, .program_timing_clock, .scl_in, .sda_in, .sda_out, .sda_oe,
  .chip_select_pin_0, .chip_select_pin_1, .chip_select_pin_2, .ew_busy);
`default_nettype wire

// ### tb/i2c_master_model.sv
// Two-wire bus master that clocks transfers toward the slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int HALF = 20
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // Both lines released, so the bus starts idle
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Release data, raise clock, then pull data down under it
  task automatic start();
    pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(HALF / 2);
  endtask
  // Data goes high only once the clock is high
  task automatic stop();
    pull = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b0;
    tick(HALF);
  endtask
  // Set mid-low, sample mid-high: never moves under a high clock
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF / 2);
    r = sda;
    tick(HALF / 2);
    scl = 1'b0;
    tick(HALF / 2);
  endtask
  // Eight bits MSB first, then the extra acknowledge pulse
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
      output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
endmodule
`default_nettype wire

// ### tb/serial_eeprom_i2c_slave_tb_top.sv
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_tb_top;
  logic clk, rst_b, ptc_raw, ptc_en, scl, m_pull, sda_oe, sda_out, ew_busy, ak;
  logic [2:0] pins;
  logic [7:0] q;
  wire sda;
  int n_errors, checks_done, ptr, s;
  int mem[int];

  // Open-drain wire: low if either party pulls
  assign sda = !((sda_oe && !sda_out) || m_pull);

  serial_eeprom_i2c_slave #(.EW_ONE_CYCLES(16'h0028), .EW_TWO_CYCLES(16'h0050)) uut (
    .clk, .rst_b, .program_timing_clock(ptc_raw & ptc_en), .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe, .chip_select_pin_0(pins[0]), .chip_select_pin_1(pins[1]),
    .chip_select_pin_2(pins[2]), .ew_busy);
  i2c_master_model #(.HALF(20)) m (.clk, .sda, .scl, .pull(m_pull));

  // System clock, and a programming clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    ptc_raw = 1'b0;
    #13;
    forever #40 ptc_raw = ~ptc_raw;  // Even phases; rate scaled with timer counts
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {serial_eeprom_pkg::DEV_TYPE, pins, rw};
  endfunction
  // Start plus own address, expecting an answer
  task automatic open(input logic rw);
    m.start();
    m.xfer(dev(rw), 1'b1, q, ak);
    check(8'(ak), 8'h00);
  endtask
  // Third and later data bytes must be refused and dropped
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    open(1'b0);
    m.xfer(a, 1'b1, q, ak);
    check(8'(ak), 8'h00);
    ptr = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xfer(d, 1'b1, q, ak);
      check(8'(ak), i < 2 ? 8'h00 : 8'h01);
      if (i < 2) begin  // Only two bytes are ever programmed
        mem[ptr] = d;
        ptr = (ptr + 1) % 256;
      end
    end
    m.stop();
  endtask
  // Last byte left unanswered, then the line must stay released
  task automatic rd(input int n);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, i == n - 1, q, ak);
      check(q, 8'(mem[ptr]));
      ptr = (ptr + 1) % 256;
    end
    check(8'(sda_oe), 8'h00);
    m.stop();
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (ew_busy !== 1'b0 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k == 5000) begin
      n_errors++;
      $display("Error at %0t: erase/write never ended", $time);
      close_out();
    end
  endtask

  // Main sequence
  initial begin
    s = $urandom(91792);
    n_errors = 0;
    checks_done = 0;
    // A clean falling edge before the first clock, so both async resets fire
    rst_b = 1'b1;
    #1;
    rst_b = 1'b0;
    ptc_en = 1'b1;
    pins = 3'($urandom);
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (40) @(negedge clk);
    // Every pin setting a shared bus may use; only our own answers
    for (int p = 0; p < 8; p++) begin
      m.start();
      m.xfer({serial_eeprom_pkg::DEV_TYPE, 3'(p), 1'b0}, 1'b1, q, ak);
      check(8'(ak), 8'(p != pins));
      m.stop();
    end
    $display("Test chip select done");
    wr(8'h01, 1);
    repeat (8) @(negedge clk);
    check(8'(ew_busy), 8'h01);
    m.start();
    m.xfer(dev(1'b0), 1'b1, q, ak);
    check(8'(ak), 8'h01);
    m.stop();
    wait_idle();
    $display("Test single write done");
    wr(8'hff, 3);
    wait_idle();
    $display("Test wrapping write done");
    ptc_en = 1'b0;
    open(1'b0);
    m.xfer(8'hff, 1'b1, q, ak);
    check(8'(ak), 8'h00);
    ptr = 8'hff;
    open(1'b1);
    rd(2);
    ptc_en = 1'b1;
    $display("Test addressed read done");
    open(1'b1);
    rd(1);
    $display("Test immediate read done");
    close_out();
  end
endmodule
`default_nettype wire
